// ===== tc_verif_defines.vh
// Contract
// - Every rejected telecommand produces an acceptance-failure report, service 1 subtype 2.
// - Failure data: packet id, sequence control, reason code, optional parameters.
// - Packet id echoes the command header id field, identifier plus top 5 bits.
// - Sequence control is copied unchanged from the command being verified.
// - Standard reason codes 0 to 5 name the fixed rejection causes.
// - Reason codes 16 to 255 are application specific.
// - Reason code value selects the parameter field content and structure.
// - Standard reasons carry the offending value as parameter.
// - Code plus parameters are whole 16-bit words, at most 40 octets.
// - Commands nominally start executing immediately after reception.
// - Optional execution-started report, subtype 3, same layout as acceptance success.
// - Progress report, subtype 5, issued as each long sub-step completes.
// - Progress report appends a 2-octet step number after id and sequence.
// - Execution-completed report, subtype 7, same layout as acceptance success.
// - Execution-failure report, subtype 8, uses acceptance-failure layout.
// - Acceptance-success report, subtype 1, holds only packet id and sequence.
// - Every accepted command gets a success report within two seconds.
`ifndef TC_VERIF_DEFINES_VH
`define TC_VERIF_DEFINES_VH
`define SVC_TYPE 8'h01
`define SUB_ACC_OK 8'h01
`define SUB_ACC_FAIL 8'h02
`define SUB_START 8'h03
`define SUB_PROGRESS 8'h05
`define SUB_DONE 8'h07
`define SUB_EXEC_FAIL 8'h08
`define SUB_CONTENTS 8'h09
`define RSN_APID 16'h0000
`define RSN_LENGTH 16'h0001
`define RSN_CHECKSUM 16'h0002
`define RSN_TYPE 16'h0003
`define RSN_SUBTYPE 16'h0004
`define RSN_APPDATA 16'h0005
`define RSN_APP_MIN 16'h0010
`define RSN_APP_MAX 16'h00FF
`define MAX_CODE_PARAM_WORDS 5'd20
`define CLK_HZ 25000000
`define ACC_LIMIT_S 2
`endif

// ===== tc_verification_report_gen.v
`timescale 1ns/100ps
`include "tc_verif_defines.vh"
module tc_verification_report_gen #(
  parameter ACC_LIMIT_CYC = `ACC_LIMIT_S * `CLK_HZ
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire ev_valid_i,
  input wire [7:0] ev_subtype_i,
  input wire [15:0] ev_pkt_id_i,
  input wire [15:0] ev_seq_ctl_i,
  input wire [15:0] ev_code_i,
  input wire [4:0] ev_param_words_i,
  input wire [15:0] ev_param_i,
  input wire tm_ready_i,
  output reg ev_ready_o,
  output reg param_take_o,
  output reg ev_error_o,
  output reg late_ack_o,
  output reg tm_valid_o,
  output reg [15:0] tm_data_o,
  output reg tm_first_o,
  output reg tm_last_o,
  output reg [7:0] tm_subtype_o
);
  localparam S_IDLE = 3'b001;
  localparam S_SEND = 3'b010;
  localparam S_PARAM = 3'b100;
  reg [2:0] state;
  reg [1:0] idx;
  reg [1:0] hdr_words;
  reg [4:0] par_left;
  reg [15:0] pkt_id;
  reg [15:0] seq_ctl;
  reg [15:0] code;
  reg [2:0] phase;
  reg [31:0] acc_age;
  reg acc_pending;
  reg acc_seen;

  // Words after id and sequence: 0 for success layouts, 1 for code or step
  function [1:0] extra_words;
    input [7:0] sub;
    begin
      case (sub)
        `SUB_ACC_FAIL, `SUB_EXEC_FAIL, `SUB_PROGRESS: extra_words = 2'd1;
        default: extra_words = 2'd0;
      endcase
    end
  endfunction

  // Ordering phase per subtype: 1 accept, 2 start, 3 progress, 4 end
  function [2:0] sub_phase;
    input [7:0] sub;
    begin
      case (sub)
        `SUB_ACC_OK, `SUB_ACC_FAIL: sub_phase = 3'd1;
        `SUB_START: sub_phase = 3'd2;
        `SUB_PROGRESS: sub_phase = 3'd3;
        `SUB_DONE, `SUB_EXEC_FAIL: sub_phase = 3'd4;
        default: sub_phase = 3'd0;
      endcase
    end
  endfunction

  // Reason code class: 1 standard, 2 application specific, 0 reserved
  function [1:0] code_class;
    input [15:0] c;
    begin
      if (c <= `RSN_APPDATA) begin
        code_class = 2'd1;
      end else if ((c >= `RSN_APP_MIN) && (c <= `RSN_APP_MAX)) begin
        code_class = 2'd2;
      end else begin
        code_class = 2'd0;
      end
    end
  endfunction

  wire known = (sub_phase(ev_subtype_i) != 3'd0);
  wire [1:0] cls = code_class(ev_code_i);
  wire is_fail = (ev_subtype_i == `SUB_ACC_FAIL) ||
                 (ev_subtype_i == `SUB_EXEC_FAIL);
  // Reserved gap 6..15 is rejected for acceptance failures
  wire code_ok = (ev_subtype_i != `SUB_ACC_FAIL) ||
                 (cls != 2'd0);
  // Standard reasons must carry the offending value as one word or more
  wire std_ok = (ev_subtype_i != `SUB_ACC_FAIL) || (cls != 2'd1) ||
                (ev_param_words_i != 5'd0);
  wire len_ok = !is_fail ||
                (ev_param_words_i < `MAX_CODE_PARAM_WORDS);
  wire same_cmd = (ev_pkt_id_i == pkt_id) && (ev_seq_ctl_i == seq_ctl);
  // A new command always opens with an acceptance report
  wire opens_cmd = (sub_phase(ev_subtype_i) == 3'd1);
  // Follow-on reports must belong to the open command, in equal or higher phase
  wire phase_ok = (sub_phase(ev_subtype_i) >= phase) &&
                  (phase != 3'd4) && (phase != 3'd0);
  wire order_ok = opens_cmd || (same_cmd && phase_ok);
  wire accept = ev_valid_i && ev_ready_o;
  wire good = known && code_ok && std_ok && len_ok && order_ok;
  wire [1:0] next_idx = idx + 2'd1;

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      idx <= 2'd0;
      hdr_words <= 2'd0;
      par_left <= 5'd0;
      pkt_id <= 16'h0000;
      seq_ctl <= 16'h0000;
      code <= 16'h0000;
      phase <= 3'd0;
      acc_age <= 32'd0;
      acc_pending <= 1'b0;
      acc_seen <= 1'b0;
      ev_ready_o <= 1'b0;
      param_take_o <= 1'b0;
      ev_error_o <= 1'b0;
      late_ack_o <= 1'b0;
      tm_valid_o <= 1'b0;
      tm_data_o <= 16'h0000;
      tm_first_o <= 1'b0;
      tm_last_o <= 1'b0;
      tm_subtype_o <= 8'h00;
    end else begin
      ev_error_o <= 1'b0;
      param_take_o <= 1'b0;
      late_ack_o <= 1'b0;
      // Age of the current unreported accepted command
      if (!acc_pending) begin
        acc_age <= 32'd0;
      end else if (acc_age < ACC_LIMIT_CYC) begin
        acc_age <= acc_age + 32'd1;
      end
      // Pulses once: the age saturates at the limit
      if (acc_pending && acc_age == ACC_LIMIT_CYC - 1) begin
        late_ack_o <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          ev_ready_o <= 1'b1;
          if (accept) begin
            // Report starts at once, nothing is queued
            ev_ready_o <= 1'b0;
            if (!good) begin
              ev_error_o <= 1'b1;
            end else begin
              pkt_id <= ev_pkt_id_i;
              seq_ctl <= ev_seq_ctl_i;
              code <= ev_code_i;
              phase <= sub_phase(ev_subtype_i);
              hdr_words <= extra_words(ev_subtype_i) + 2'd1;
              par_left <= is_fail ? ev_param_words_i : 5'd0;
              tm_subtype_o <= ev_subtype_i;
              tm_data_o <= ev_pkt_id_i;
              tm_valid_o <= 1'b1;
              tm_first_o <= 1'b1;
              tm_last_o <= 1'b0;
              idx <= 2'd0;
              // Later reports without a success report start the age
              if (ev_subtype_i == `SUB_ACC_OK) begin
                acc_seen <= 1'b1;
                acc_pending <= 1'b0;
              end else if (opens_cmd) begin
                acc_seen <= 1'b0;
                acc_pending <= 1'b0;
              end else if (!acc_seen) begin
                acc_pending <= 1'b1;
              end
              state <= S_SEND;
            end
          end
        end
        S_SEND: begin
          if (tm_ready_i) begin
            tm_first_o <= 1'b0;
            if (tm_last_o) begin
              tm_valid_o <= 1'b0;
              tm_last_o <= 1'b0;
              ev_ready_o <= 1'b1;
              state <= S_IDLE;
            end else if (idx == hdr_words) begin
              // Parameter words follow the code
              tm_data_o <= ev_param_i;
              param_take_o <= 1'b1;
              par_left <= par_left - 5'd1;
              tm_last_o <= (par_left == 5'd1);
              state <= S_PARAM;
            end else begin
              idx <= next_idx;
              // Sequence control first, then code or step number
              if (next_idx == 2'd1) begin
                tm_data_o <= seq_ctl;
              end else begin
                tm_data_o <= code;
              end
              tm_last_o <= (next_idx == hdr_words) &&
                           (par_left == 5'd0);
            end
          end
        end
        S_PARAM: begin
          if (tm_ready_i) begin
            if (tm_last_o) begin
              tm_valid_o <= 1'b0;
              tm_last_o <= 1'b0;
              ev_ready_o <= 1'b1;
              state <= S_IDLE;
            end else begin
              // Each further word reads the next parameter
              tm_data_o <= ev_param_i;
              param_take_o <= 1'b1;
              par_left <= par_left - 5'd1;
              tm_last_o <= (par_left == 5'd1);
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tm_sink.sv
`timescale 1ns/100ps
module tm_sink (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire tm_valid_o,
  output reg tm_ready_i = 1'b0
);
  integer s = 32'h1F2E3D4C;
  // Stalls about one cycle in four
  always @(posedge ref_clk_i) begin
    tm_ready_i <= !sys_rst_i && (($random(s) & 3) != 0);
  end
endmodule

// ===== tc_verif_checker.sv
`timescale 1ns/100ps
module tc_verif_checker (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire ev_valid_i,
  input wire [7:0] ev_subtype_i,
  input wire [15:0] ev_pkt_id_i,
  input wire [15:0] ev_seq_ctl_i,
  input wire [15:0] ev_code_i,
  input wire tm_ready_i,
  input wire ev_ready_o,
  input wire param_take_o,
  input wire ev_error_o,
  input wire tm_valid_o,
  input wire [15:0] tm_data_o,
  input wire tm_first_o,
  input wire tm_last_o,
  input wire [7:0] tm_subtype_o
);
  reg [15:0] seq_q = 16'h0000;
  reg [7:0] sub_q = 8'h00;
  wire take = ev_valid_i && ev_ready_o;
  always @(posedge ref_clk_i) begin
    if (take) begin
      seq_q <= ev_seq_ctl_i;
      sub_q <= ev_subtype_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_ID: assert property (take |=> ev_error_o ||
    (tm_first_o && tm_data_o == $past(ev_pkt_id_i))) else $error("id");
  AST_SEQ: assert property (tm_valid_o && tm_first_o && tm_ready_i
    |=> tm_data_o == seq_q && !tm_first_o) else $error("seq");
  AST_SUB: assert property (tm_valid_o && tm_first_o
    |-> tm_subtype_o == sub_q) else $error("subtype");
  AST_REF9: assert property (take && ev_subtype_i == 8'h09
    |=> ev_error_o && !tm_valid_o) else $error("sub9");
  AST_RSV: assert property (take && ev_subtype_i == 8'h02 &&
    ev_code_i inside {[6:15]} |=> ev_error_o) else $error("code");
  AST_HOLD: assert property (tm_valid_o && !tm_ready_i |=>
    tm_valid_o && $stable(tm_data_o) && $stable(tm_last_o)) else $error("hold");
  AST_BUSY: assert property (tm_valid_o |-> !ev_ready_o)
    else $error("busy");
  AST_ERR: assert property (ev_error_o |=> !ev_error_o && ev_ready_o)
    else $error("err");
  AST_PAR: assert property (param_take_o |-> tm_valid_o && !tm_first_o)
    else $error("param");
  cover property (tm_valid_o && tm_last_o && tm_ready_i);
  cover property (ev_error_o);
  cover property (param_take_o && tm_last_o);
endmodule
bind tc_verification_report_gen tc_verif_checker chk (.*);

// ===== test_tc_verification_report_gen.sv
`timescale 1ns/100ps
module test_tc_verification_report_gen;
  reg ref_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg ev_valid_i = 1'b0;
  reg [7:0] ev_subtype_i = 8'h00;
  reg [15:0] ev_pkt_id_i = 16'h0000;
  reg [15:0] ev_seq_ctl_i = 16'h0000;
  reg [15:0] ev_code_i = 16'h0000;
  reg [4:0] ev_param_words_i = 5'h00;
  reg [15:0] ev_param_i = 16'hA000;
  wire tm_ready_i, ev_ready_o, param_take_o, ev_error_o, late_ack_o;
  wire tm_valid_o, tm_first_o, tm_last_o;
  wire [15:0] tm_data_o;
  wire [7:0] tm_subtype_o;
  integer seed = 32'hFC7E5FC3;
  integer error_cnt = 0;
  integer check_count = 0;
  integer j;
  integer late_cnt = 0;
  reg [15:0] id, sq;
  reg [25:0] exp_q[$];
  initial forever #20 ref_clk_i = ~ref_clk_i;
  tc_verification_report_gen #(.ACC_LIMIT_CYC(100)) uut (.*);
  tm_sink sink (.*);
  task chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task conclude;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task new_cmd;
    id = $random(seed);
    sq = $random(seed);
  endtask
  task req(input [7:0] s, input [15:0] c, input [4:0] n, input bit e);
    integer k;
    bit sh;
    @(posedge ref_clk_i);
    ev_valid_i <= 1'b1;
    ev_subtype_i <= s;
    ev_code_i <= c;
    ev_param_words_i <= n;
    ev_pkt_id_i <= id;
    ev_seq_ctl_i <= sq;
    do @(posedge ref_clk_i); while (ev_ready_o !== 1'b1);
    ev_valid_i <= 1'b0;
    sh = (s == 1 || s == 3 || s == 7);
    if (!(s == 2 || s == 8)) n = 0;
    if (!e) begin
      exp_q.push_back({s, 2'b10, id});
      exp_q.push_back({s, 1'b0, sh, sq});
      if (!sh) exp_q.push_back({s, 1'b0, n == 0, c});
      for (k = 0; k < n; k++) exp_q.push_back({s, 1'b0, k == n - 1, 16'hA000 + k[15:0]});
    end
    #1 chk(ev_error_o === e, "refusal");
  endtask
  always @(posedge ref_clk_i) begin
    if (tm_valid_o === 1'b1 && tm_ready_i) chk(exp_q.size() > 0 && exp_q.pop_front() === {tm_subtype_o, tm_first_o, tm_last_o, tm_data_o}, "word");
    if (late_ack_o === 1'b1) late_cnt = late_cnt + 1;
  end
  // Next parameter must stand before the edge that follows a take
  always @(negedge ref_clk_i) begin
    if (tm_first_o === 1'b1) ev_param_i <= 16'hA000;
    else if (param_take_o === 1'b1) ev_param_i <= ev_param_i + 16'h0001;
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    new_cmd;
    req(1, 0, 0, 0);
    req(3, 0, 0, 0);
    req(5, $random(seed), 0, 0);
    req(5, 16'h0002, 0, 0);
    req(7, 0, 0, 0);
    req(8, 16'h0010, 1, 1);
    for (j = 0; j < 6; j++) begin
      new_cmd;
      req(2, j[15:0], j[4:0] + 5'h01, 0);
    end
    new_cmd;
    req(2, 16'h00FF, 19, 0);
    req(8, 16'h0020, 2, 0);
    new_cmd;
    req(2, 16'h0006, 1, 1);
    req(2, 16'h000F, 1, 1);
    req(2, 16'h0003, 0, 1);
    req(2, 16'h0010, 20, 1);
    req(9, 0, 0, 1);
    req(4, 0, 0, 1);
    req(5, 0, 0, 1);
    req(1, 0, 0, 0);
    req(5, 16'h0001, 0, 0);
    req(3, 0, 0, 1);
    new_cmd;
    req(2, 16'h0011, 0, 0);
    req(3, 0, 0, 0);
    repeat (110) @(posedge ref_clk_i);
    repeat (20) begin
      new_cmd;
      req(2, 16'h0010 | ($random(seed) & 16'h00FF), $random(seed) & 15, 0);
    end
    repeat (100) @(posedge ref_clk_i);
    chk(exp_q.size() == 0, "missing words");
    chk(late_cnt == 1, "late acceptance pulse");
    conclude;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    conclude;
  end
endmodule
